// *** hw/lcd_load_clock_ctrl.sv ***
`timescale 1ns/100ps
// What this block does
// RQ1: load output is clock divided 1,2,3,4,5,8; at divide by 1 the code holds it high
// RQ2: half and quarter rate copies of load
// RQ3: second load output gated without partial pulses
// RQ4: lsb select pin, serial clock in serial mode
// RQ5: msb select pin, serial data in serial mode
// RQ6: disable low tristates clocks, default enabled
// RQ7: reprogram frequencies while running, no reset
// RQ8: select 00 a, 01 b, 1x c
// RQ9: gated load low unless enable, synced to load
// RQ10: all load outputs from one common edge
module lcd_load_clock_ctrl #(
  parameter int SET_W = 24
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // device pins in
  input  wire logic                          freq_select_lsb,
  input  wire logic                          freq_select_msb,
  input  wire logic                          output_tristate_control_n,
  input  wire logic                          load_enable,
  // load outputs
  output logic                               primary_load_out,
  output logic                               load_half_out,
  output logic                               load_quarter_out,
  output logic                               gated_load_out,
  // output enables of the clock pins
  output logic                               load_outputs_oe,
  output logic                               video_clock_out_oe,
  output logic                               memory_clock_out_oe,
  // video frequency selection
  output logic [1:0]                         video_setting_index,
  output logic [SET_W-1:0]                   video_setting_word,
  // serial programming pins passed on
  output logic                               serial_mode_out,
  output logic                               serial_clock_out,
  output logic                               serial_data_out
);
  import lcd_pkg::*;

  logic [LCD_PIN_N-1:0] pin_raw;
  logic [LCD_PIN_N-1:0] pin_s1_q;
  logic [LCD_PIN_N-1:0] pin_s2_q;
  logic [LCD_PIN_N-1:0] pin_s3_q;
  logic [LCD_PIN_N-1:0] pin_q;
  logic                 serial_mode_q;
  logic [2:0]           div_code_q;
  logic [SET_W-1:0]     set_a_q;
  logic [SET_W-1:0]     set_b_q;
  logic [SET_W-1:0]     set_c_q;
  logic [1:0]           idx_q;
  logic [1:0]           idx_d;
  logic [SET_W-1:0]     word_q;
  logic                 oe_q;
  logic                 ser_clk_q;
  logic                 ser_dat_q;
  logic [31:0]          prdata_q;
  logic [31:0]          rdata_d;
  logic                 pready_q;
  logic                 pslverr_q;
  logic                 err_d;
  logic                 access;
  logic                 wr_commit;
  logic [LCD_FAC_W-1:0] active_factor;

  assign pin_raw = {load_enable, output_tristate_control_n, freq_select_msb, freq_select_lsb};

  // three-stage synchronisers; a change counts once stages two and three agree
  generate
    for (genvar i = 0; i < LCD_PIN_N; i++) begin : g_pin
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_s1_q[i] <= LCD_PIN_RST[i];
          pin_s2_q[i] <= LCD_PIN_RST[i];
          pin_s3_q[i] <= LCD_PIN_RST[i];
          pin_q[i]    <= LCD_PIN_RST[i];                     // [RQ4] [RQ5] [RQ6]
        end else begin
          pin_s1_q[i] <= pin_raw[i];
          pin_s2_q[i] <= pin_s1_q[i];
          pin_s3_q[i] <= pin_s2_q[i];
          if (pin_s2_q[i] == pin_s3_q[i]) begin
            pin_q[i] <= pin_s3_q[i];
          end
        end
      end
    end
  endgenerate

  // apb access phase; one wait state keeps pready a flop output
  assign access    = psel & penable;
  assign wr_commit = access & pready_q & pwrite & ~pslverr_q;

  // decode, read data and error for the access in flight
  always_comb begin
    rdata_d = '0;
    err_d   = 1'b0;
    case (paddr)
      LCD_OFS_CTRL: begin
        rdata_d[LCD_CTRL_SERIAL_BIT] = serial_mode_q;
      end
      LCD_OFS_DIV: begin
        rdata_d[2:0] = div_code_q;
        err_d        = pwrite & (pwdata[2:0] > LCD_DIV_CODE_MAX);
      end
      LCD_OFS_SET_A: begin
        rdata_d[SET_W-1:0] = set_a_q;
      end
      LCD_OFS_SET_B: begin
        rdata_d[SET_W-1:0] = set_b_q;
      end
      LCD_OFS_SET_C: begin
        rdata_d[SET_W-1:0] = set_c_q;
      end
      LCD_OFS_STATUS: begin
        rdata_d[LCD_ST_PINS_LSB +: LCD_PIN_N] = pin_q;
        rdata_d[LCD_ST_IDX_LSB +: 2]          = idx_q;
        rdata_d[LCD_ST_FAC_LSB +: LCD_FAC_W]  = active_factor;
        err_d                                 = pwrite;
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // bus answer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & err_d;
      prdata_q  <= (access & ~pready_q & ~pwrite) ? rdata_d : '0;
    end
  end

  // software registers; writes land at the completing edge only
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_mode_q <= 1'b0;
      div_code_q    <= LCD_DIV_CODE_RST;
      set_a_q       <= '0;
      set_b_q       <= '0;
      set_c_q       <= '0;
    end else if (wr_commit) begin
      case (paddr)
        LCD_OFS_CTRL:  serial_mode_q <= pwdata[LCD_CTRL_SERIAL_BIT];
        LCD_OFS_DIV:   div_code_q    <= pwdata[2:0];          // [RQ7]
        LCD_OFS_SET_A: set_a_q       <= pwdata[SET_W-1:0];   // [RQ7]
        LCD_OFS_SET_B: set_b_q       <= pwdata[SET_W-1:0];   // [RQ7]
        LCD_OFS_SET_C: set_c_q       <= pwdata[SET_W-1:0];   // [RQ7]
        default: ;
      endcase
    end
  end

  // select decode; in serial mode the pins carry data, so the choice is frozen
  always_comb begin
    if (serial_mode_q) begin
      idx_d = idx_q;
    end else if (pin_q[LCD_PIN_SEL_MSB]) begin
      idx_d = LCD_IDX_C;                                     // [RQ5] [RQ8]
    end else if (pin_q[LCD_PIN_SEL_LSB]) begin
      idx_d = LCD_IDX_B;                                     // [RQ4] [RQ8]
    end else begin
      idx_d = LCD_IDX_A;                                     // [RQ8]
    end
  end

  // selected setting follows live register contents
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_q  <= LCD_IDX_A;
      word_q <= '0;
    end else begin
      idx_q <= idx_d;
      case (idx_q)
        LCD_IDX_A: word_q <= set_a_q;                        // [RQ8]
        LCD_IDX_B: word_q <= set_b_q;                        // [RQ8]
        default:   word_q <= set_c_q;                        // [RQ8]
      endcase
    end
  end

  // serial pins are forwarded only in serial mode, low otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      ser_clk_q <= 1'b0;
      ser_dat_q <= 1'b0;
    end else begin
      ser_clk_q <= serial_mode_q & pin_q[LCD_PIN_SEL_LSB];   // [RQ4]
      ser_dat_q <= serial_mode_q & pin_q[LCD_PIN_SEL_MSB];   // [RQ5]
    end
  end

  // output disable; reset level high means enabled when the pin floats
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_q <= 1'b1;
    end else begin
      oe_q <= pin_q[LCD_PIN_TRI_N];                          // [RQ6]
    end
  end

  // divider chain
  lcd_load_div u_div (
    .clk             (clk),
    .rst             (rst),
    .factor          (lcd_div_factor(div_code_q)),
    .load_enable     (pin_q[LCD_PIN_LOAD_EN]),
    .primary_load_q  (primary_load_out),
    .load_half_q     (load_half_out),
    .load_quarter_q  (load_quarter_out),
    .gated_load_q    (gated_load_out),
    .active_factor_q (active_factor)
  );

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign load_outputs_oe     = oe_q;
  assign video_clock_out_oe  = oe_q;
  assign memory_clock_out_oe = oe_q;
  assign video_setting_index = idx_q;
  assign video_setting_word  = word_q;
  assign serial_mode_out     = serial_mode_q;
  assign serial_clock_out    = ser_clk_q;
  assign serial_data_out     = ser_dat_q;

endmodule

// *** hw/lcd_pkg.sv ***
package lcd_pkg;

  // apb byte offsets, one aligned word each
  localparam logic [7:0] LCD_OFS_CTRL   = 8'h00;
  localparam logic [7:0] LCD_OFS_DIV    = 8'h04;
  localparam logic [7:0] LCD_OFS_SET_A  = 8'h08;
  localparam logic [7:0] LCD_OFS_SET_B  = 8'h0C;
  localparam logic [7:0] LCD_OFS_SET_C  = 8'h10;
  localparam logic [7:0] LCD_OFS_STATUS = 8'h14;

  // control register fields
  localparam int LCD_CTRL_SERIAL_BIT = 0;

  // status register fields
  localparam int LCD_ST_PINS_LSB = 0;
  localparam int LCD_ST_IDX_LSB  = 4;
  localparam int LCD_ST_FAC_LSB  = 8;

  // load divisor codes and reset value
  localparam logic [2:0] LCD_DIV_CODE_MAX = 3'h5;
  localparam logic [2:0] LCD_DIV_CODE_RST = 3'h3;
  localparam int         LCD_FAC_W        = 4;

  // filtered pin vector layout and reset levels
  localparam int         LCD_PIN_N       = 4;
  localparam int         LCD_PIN_SEL_LSB = 0;
  localparam int         LCD_PIN_SEL_MSB = 1;
  localparam int         LCD_PIN_TRI_N   = 2;
  localparam int         LCD_PIN_LOAD_EN = 3;
  localparam logic [3:0] LCD_PIN_RST     = 4'h4;

  // selected video setting index
  localparam logic [1:0] LCD_IDX_A = 2'h0;
  localparam logic [1:0] LCD_IDX_B = 2'h1;
  localparam logic [1:0] LCD_IDX_C = 2'h2;

  // divisor code to division factor
  function automatic logic [LCD_FAC_W-1:0] lcd_div_factor(input logic [2:0] code);
    case (code)
      3'h0:    lcd_div_factor = 4'h1;
      3'h1:    lcd_div_factor = 4'h2;
      3'h2:    lcd_div_factor = 4'h3;
      3'h3:    lcd_div_factor = 4'h4;
      3'h4:    lcd_div_factor = 4'h5;
      default: lcd_div_factor = 4'h8;
    endcase
  endfunction

endpackage

// *** hw/lcd_load_div.sv ***
`timescale 1ns/100ps
module lcd_load_div (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // control
  input  wire logic [lcd_pkg::LCD_FAC_W-1:0] factor,
  input  wire logic                         load_enable,
  // load outputs
  output logic                              primary_load_q,
  output logic                              load_half_q,
  output logic                              load_quarter_q,
  output logic                              gated_load_q,
  output logic [lcd_pkg::LCD_FAC_W-1:0]     active_factor_q
);
  import lcd_pkg::*;

  logic [LCD_FAC_W-1:0] cnt_q;
  logic [LCD_FAC_W-1:0] cnt_d;
  logic [LCD_FAC_W-1:0] fac_next;
  logic [LCD_FAC_W-1:0] high_len;
  logic                 wrap;
  logic                 load_d;
  logic                 en_q;

  // period boundary; a new factor is only taken here so no runt pulse appears
  assign wrap     = (cnt_q == LCD_FAC_W'(active_factor_q - 4'h1));
  assign cnt_d    = wrap ? '0 : LCD_FAC_W'(cnt_q + 4'h1);
  assign fac_next = wrap ? factor : active_factor_q;          // [RQ7]
  assign high_len = LCD_FAC_W'((fac_next + 4'h1) >> 1);
  assign load_d   = (cnt_d < high_len);                      // [RQ1]

  // period counter and factor in use
  always_ff @(posedge clk) begin
    if (rst) begin
      // start on the last count so the first period is whole and lines up with the copies
      cnt_q           <= LCD_FAC_W'(lcd_div_factor(LCD_DIV_CODE_RST) - 4'h1);  // [RQ10]
      active_factor_q <= lcd_div_factor(LCD_DIV_CODE_RST);
    end else begin
      cnt_q           <= cnt_d;
      active_factor_q <= fac_next;                           // [RQ7]
    end
  end

  // all load copies share this edge and the same wrap event
  always_ff @(posedge clk) begin
    if (rst) begin
      primary_load_q <= 1'b0;
      load_half_q    <= 1'b0;
      load_quarter_q <= 1'b0;
    end else begin
      primary_load_q <= load_d;                              // [RQ1] [RQ10]
      if (wrap) begin
        load_half_q <= ~load_half_q;                         // [RQ2] [RQ10]
      end
      if (wrap && load_half_q) begin
        load_quarter_q <= ~load_quarter_q;                   // [RQ2] [RQ10]
      end
    end
  end

  // enable sampled once per load period, so gating never cuts a pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q         <= 1'b0;
      gated_load_q <= 1'b0;
    end else begin
      if (wrap) begin
        en_q <= load_enable;                                 // [RQ9]
      end
      gated_load_q <= load_d & (wrap ? load_enable : en_q);  // [RQ3] [RQ9] [RQ10]
    end
  end

endmodule

// *** verification/lcd_ctrl_sva.sv ***
`timescale 1ns/100ps
module lcd_ctrl_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // pins and outputs
  input wire logic       output_tristate_control_n,
  input wire logic       primary_load_out,
  input wire logic       load_half_out,
  input wire logic       load_quarter_out,
  input wire logic       gated_load_out,
  input wire logic       load_outputs_oe,
  input wire logic       video_clock_out_oe,
  input wire logic       memory_clock_out_oe,
  input wire logic [1:0] video_setting_index,
  input wire logic       serial_mode_out,
  input wire logic       serial_clock_out,
  input wire logic       serial_data_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // two phases of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  // serial mode off for two samples in a row
  sequence s_serial_off;
    !serial_mode_out ##1 !serial_mode_out;
  endsequence
  AST_APB_ANSWER: assert property (s_setup ##1 s_access |=> pready)
    else $error("late answer");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("long answer");
  AST_GATED_SUBSET: assert property (gated_load_out |-> primary_load_out)
    else $error("partial gated pulse");
  // gated output may only change at a period start or together with the primary load
  AST_GATED_WHOLE: assert property ($changed(gated_load_out) |->
    $changed(load_half_out) || $changed(primary_load_out)) else $error("gated cut mid pulse");
  AST_HALF_ALIGN: assert property ($changed(load_half_out) |-> primary_load_out)
    else $error("half off edge");
  AST_HALF_ON_RISE: assert property ($rose(primary_load_out) && !$past(rst) |-> $changed(load_half_out))
    else $error("half missed");
  AST_QUARTER_ALIGN: assert property ($changed(load_quarter_out) |-> $changed(load_half_out))
    else $error("quarter off edge");
  AST_OE_SAME: assert property (load_outputs_oe == video_clock_out_oe && load_outputs_oe == memory_clock_out_oe)
    else $error("oe differ");
  AST_OE_OFF: assert property (!output_tristate_control_n [*8] |-> !load_outputs_oe)
    else $error("not tristated");
  AST_OE_ON: assert property (output_tristate_control_n [*8] |-> load_outputs_oe)
    else $error("not driven");
  AST_SERIAL_QUIET: assert property (s_serial_off |-> !serial_clock_out && !serial_data_out)
    else $error("serial leak");
  AST_INDEX_LEGAL: assert property (video_setting_index != 2'h3)
    else $error("bad index");
endmodule

bind lcd_load_clock_ctrl lcd_ctrl_sva i_sva (.clk, .rst, .psel, .penable, .pready, .output_tristate_control_n,
  .primary_load_out, .load_half_out, .load_quarter_out, .gated_load_out, .load_outputs_oe, .video_clock_out_oe,
  .memory_clock_out_oe, .video_setting_index, .serial_mode_out, .serial_clock_out, .serial_data_out);

// *** verification/lcd_host_pins.sv ***
`timescale 1ns/100ps
module lcd_host_pins (
  // clock
  input  wire logic       clk,
  // requests from the bench
  input  wire logic [1:0] sel_code,
  input  wire logic       disable_req,
  input  wire logic       enable_req,
  input  wire logic       release_req,
  input  wire logic       slow,
  // pins toward the device
  output logic            freq_select_lsb,
  output logic            freq_select_msb,
  output logic            output_tristate_control_n,
  output logic            load_enable
);
  logic [3:0] stage_q;
  logic [3:0] cur;
  // a slow host shows each request except release one cycle late
  always_ff @(posedge clk) begin
    stage_q <= {enable_req, ~disable_req, sel_code};
  end
  assign cur = slow ? stage_q : {enable_req, ~disable_req, sel_code};
  // released pins fall to their pulls: selects low, disable high
  assign freq_select_lsb           = release_req ? 1'b0 : cur[0];
  assign freq_select_msb           = release_req ? 1'b0 : cur[1];
  assign output_tristate_control_n = release_req ? 1'b1 : cur[2];
  assign load_enable               = cur[3];
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import lcd_pkg::*;
  // clock, reset and apb
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  // pins and host requests
  logic        freq_select_lsb, freq_select_msb, output_tristate_control_n, load_enable;
  logic [1:0]  code;
  logic        dis_req, en_req, rel_req, slow;
  // design outputs
  logic        primary_load_out, load_half_out, load_quarter_out, gated_load_out;
  logic        load_outputs_oe, video_clock_out_oe, memory_clock_out_oe;
  logic        serial_mode_out, serial_clock_out, serial_data_out;
  logic [1:0]  video_setting_index;
  logic [23:0] video_setting_word;
  logic [2:0]  lv, lv_q;
  int          per[3], cnt[3], fac[6], cyc, bad_count, total_checks;
  assign lv = {load_quarter_out, load_half_out, primary_load_out};

  lcd_load_clock_ctrl #(.SET_W(24)) i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .freq_select_lsb, .freq_select_msb, .output_tristate_control_n, .load_enable,
    .primary_load_out, .load_half_out, .load_quarter_out, .gated_load_out, .load_outputs_oe, .video_clock_out_oe,
    .memory_clock_out_oe, .video_setting_index, .video_setting_word, .serial_mode_out, .serial_clock_out,
    .serial_data_out);
  lcd_host_pins i_host (.clk, .sel_code(code), .disable_req(dis_req), .enable_req(en_req),
    .release_req(rel_req), .slow, .freq_select_lsb, .freq_select_msb, .output_tristate_control_n, .load_enable);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // cycles between rises of the primary, half and quarter load outputs, and the run limit
  always @(posedge clk) begin
    lv_q <= lv;
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++) begin
      cnt[i] <= (lv[i] && !lv_q[i]) ? 1 : cnt[i] + 1;
      if (lv[i] && !lv_q[i])
        per[i] <= cnt[i];
    end
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one transfer; data and error taken at the answering edge only
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic ee);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the run timeout ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", {31'h0, err}, {31'h0, ee});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0, ee);
    if (!ee)
      chk("prdata", rd, e);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    fac = '{1, 2, 3, 4, 5, 8};
    {rst, code, paddr, pwdata} = {1'b1, 42'h0};
    {psel, penable, pwrite, dis_req, en_req, rel_req, slow} = 7'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values and refused accesses
    rdc(LCD_OFS_CTRL, 32'h0, 1'b0);
    rdc(LCD_OFS_DIV, 32'h3, 1'b0);
    rdc(LCD_OFS_SET_A, 32'h0, 1'b0);
    rdc(LCD_OFS_STATUS, 32'h404, 1'b0);
    rdc(8'h18, 32'h0, 1'b1);
    apb(1'b1, LCD_OFS_STATUS, 32'hF, 1'b1);
    $display("test reset done");
    // every divisor in turn while running
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, LCD_OFS_DIV, i, 1'b0);
      repeat (100) @(posedge clk);
      rdc(LCD_OFS_STATUS, 32'h4 | (fac[i] << 8), 1'b0);
      if (i > 0)
        chk("load period", per[0], fac[i]);
      else
        chk("load high", {31'h0, primary_load_out}, 32'h1);
      chk("half period", per[1], 2 * fac[i]);
      chk("quarter period", per[2], 4 * fac[i]);
    end
    apb(1'b1, LCD_OFS_DIV, 32'h6, 1'b1);
    rdc(LCD_OFS_DIV, 32'h5, 1'b0);
    $display("test divisor done");
    // select codes pick a setting, slow host on the upper codes
    for (int i = 0; i < 3; i++)
      apb(1'b1, LCD_OFS_SET_A + 8'(4 * i), 32'h111111 * (i + 1), 1'b0);
    for (int c = 0; c < 4; c++) begin
      slow <= c[1];
      code <= c[1:0];
      repeat (10) @(posedge clk);
      chk("index", video_setting_index, c[1] ? 2 : c);
      chk("word", video_setting_word, 32'h111111 * (c[1] ? 3 : c + 1));
    end
    rel_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("released index", video_setting_index, 32'h0);
    {rel_req, slow, code} <= 4'h0;
    $display("test select done");
    // output disable
    dis_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("oe off", {load_outputs_oe, video_clock_out_oe, memory_clock_out_oe}, 32'h0);
    dis_req <= 1'b0;
    repeat (10) @(posedge clk);
    chk("oe on", {load_outputs_oe, video_clock_out_oe, memory_clock_out_oe}, 32'h7);
    $display("test disable done");
    // gated load held, then free running
    apb(1'b1, LCD_OFS_DIV, 32'h2, 1'b0);
    repeat (20) @(posedge clk) chk("gated held", gated_load_out, 32'h0);
    en_req <= 1'b1;
    repeat (20) @(posedge clk);
    repeat (20) @(posedge clk) chk("gated run", gated_load_out, primary_load_out);
    en_req <= 1'b0;
    repeat (20) @(posedge clk);
    repeat (20) @(posedge clk) chk("gated stopped", gated_load_out, 32'h0);
    $display("test gated done");
    // serial mode passes pins on and freezes the selection
    apb(1'b1, LCD_OFS_CTRL, 32'h1, 1'b0);
    code <= 2'h1;
    repeat (10) @(posedge clk);
    chk("serial lsb", {serial_mode_out, serial_clock_out, serial_data_out, video_setting_index}, 32'h18);
    code <= 2'h2;
    repeat (10) @(posedge clk);
    chk("serial msb", {serial_mode_out, serial_clock_out, serial_data_out, video_setting_index}, 32'h14);
    apb(1'b1, LCD_OFS_CTRL, 32'h0, 1'b0);
    repeat (10) @(posedge clk);
    chk("normal", {serial_mode_out, serial_clock_out, serial_data_out, video_setting_index}, 32'h2);
    $display("test serial done");
    summarize();
  end
endmodule
